/* File: hw/umh_pkg.sv */
// Package with register map, field positions, reset values and strap constants.
package umh_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB bus.
  localparam logic [7:0] UMH_OFF_P1_MCR    = 8'h00;  // Port 1 modem control register.
  localparam logic [7:0] UMH_OFF_P1_MSR    = 8'h04;  // Port 1 modem status register.
  localparam logic [7:0] UMH_OFF_P1_IER    = 8'h08;  // Port 1 interrupt enable register.
  localparam logic [7:0] UMH_OFF_P2_MCR    = 8'h10;  // Port 2 modem control register.
  localparam logic [7:0] UMH_OFF_P2_MSR    = 8'h14;  // Port 2 modem status register.
  localparam logic [7:0] UMH_OFF_P2_IER    = 8'h18;  // Port 2 interrupt enable register.
  localparam logic [7:0] UMH_OFF_INT_STAT  = 8'h20;  // Sticky interrupt status register.
  localparam logic [7:0] UMH_OFF_INT_MASK  = 8'h24;  // Interrupt mask register.
  localparam logic [7:0] UMH_OFF_STRAP     = 8'h28;  // Captured strap register.

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int UMH_MCR_TERM_READY  = 0;  // Terminal-ready request bit.
  localparam int UMH_MCR_SEND_REQ    = 1;  // Send-request bit.
  localparam int UMH_MCR_LOOPBACK    = 4;  // Loopback mode bit.
  localparam int UMH_IER_MODEM       = 3;  // Modem status interrupt enable bit.
  localparam int UMH_MSR_D_CTS       = 0;  // Clear-to-send change bit.
  localparam int UMH_MSR_D_DSR       = 1;  // Set-ready change bit.
  localparam int UMH_MSR_D_RI        = 2;  // Ring change bit.
  localparam int UMH_MSR_D_DCD       = 3;  // Carrier-detect change bit.
  localparam int UMH_MSR_CTS         = 4;  // Clear-to-send level bit.
  localparam int UMH_MSR_DSR         = 5;  // Set-ready level bit.
  localparam int UMH_MSR_RI          = 6;  // Ring level bit.
  localparam int UMH_MSR_DCD         = 7;  // Carrier-detect level bit.
  localparam int UMH_INT_P1          = 0;  // Port 1 modem interrupt status bit.
  localparam int UMH_INT_P2          = 1;  // Port 2 modem interrupt status bit.

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] UMH_MCR_RST      = 8'h00;  // Control bits clear after reset.
  localparam logic [7:0] UMH_IER_RST      = 8'h00;  // Interrupts disabled after reset.
  localparam logic [1:0] UMH_INT_RST      = 2'h0;   // No pending interrupt after reset.
  localparam logic       UMH_PIN_IDLE     = 1'b1;   // Inactive level of low-active pins.
  localparam logic [3:0] UMH_DELTA_RST    = 4'h0;   // No change recorded after reset.

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration index base selected by the strap.
  localparam logic [11:0] UMH_BASE_STRAP0 = 12'h3f0;  // Strap level 0.
  localparam logic [11:0] UMH_BASE_STRAP1 = 12'h370;  // Strap level 1.

endpackage : umh_pkg

/* File: hw/umh_port.sv */
// One serial port's modem status tracking: levels, change flags and change event.
module umh_port
  import umh_pkg::*;
(
  input  wire logic       clk,             // System clock.
  input  wire logic       sys_rst,         // Asynchronous reset, active high.
  input  wire logic       clear_to_send_n, // Clear-to-send pin, low active.
  input  wire logic       set_ready_n,     // Set-ready pin, low active.
  input  wire logic       carrier_detect_n,// Carrier-detect pin, low active.
  input  wire logic       ring_n,          // Ring pin, low active.
  input  wire logic [3:0] delta_clr,       // Change bits that a status read consumed.
  output logic      [7:0] msr_q,           // Modem status register image.
  output logic            change_q         // One-cycle pulse when any input toggled.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin history and change flags.
  logic [3:0] pins_q;   // Last sampled pins: carrier, ring, set-ready, clear-to-send.
  logic [3:0] delta_q;  // Sticky low-to-high change flags.
  logic [3:0] pins_now; // Current pins in change-flag order.
  logic [3:0] rise;     // Pins that went from low to high.
  logic [3:0] delta_d;  // Next change flags.

  // Map pins into the order of the change bits: cts, dsr, ri, dcd.
  assign pins_now = {carrier_detect_n, ring_n, set_ready_n, clear_to_send_n};
  // A pin that was low and is now high records a change.
  assign rise     = pins_now & ~pins_q;
  // New changes win over the clear from a read in the same cycle.
  assign delta_d  = (delta_q & ~delta_clr) | rise;

  // Keep the previous pin levels; idle pins read as high.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_q <= {4{UMH_PIN_IDLE}};
    end else begin
      pins_q <= pins_now;
    end
  end

  // Sticky change flags, set by a rising pin and cleared by a status read.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      delta_q <= UMH_DELTA_RST;
    end else begin
      delta_q <= delta_d;
    end
  end

  // Any edge on any of the four inputs is an interrupt-worthy event.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      change_q <= 1'b0;
    end else begin
      change_q <= |(pins_now ^ pins_q);
    end
  end

  // Status image: complemented levels on top, change flags below.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msr_q <= 8'h00;
    end else begin
      msr_q[UMH_MSR_CTS]                 <= ~clear_to_send_n;
      msr_q[UMH_MSR_DSR]                 <= ~set_ready_n;
      msr_q[UMH_MSR_DCD]                 <= ~carrier_detect_n;
      msr_q[UMH_MSR_RI]                  <= ~ring_n;
      msr_q[UMH_MSR_D_DCD:UMH_MSR_D_CTS] <= delta_d;
    end
  end

endmodule : umh_port

/* File: hw/umh_top.sv */
// Modem handshake block for two serial ports with an APB register interface.
module umh_top
  import umh_pkg::*;
(
  input  wire logic        clk,                    // System clock, 250 MHz.
  input  wire logic        sys_rst,                // Asynchronous reset, active high.
  input  wire logic        psel,                   // APB select.
  input  wire logic        penable,                // APB enable.
  input  wire logic        pwrite,                 // APB write direction.
  input  wire logic [7:0]  paddr,                  // APB byte address.
  input  wire logic [31:0] pwdata,                 // APB write data.
  output logic      [31:0] prdata,                 // APB read data.
  output logic             pready,                 // APB ready.
  output logic             pslverr,                // APB error for unmapped address.
  input  wire logic        port1_clear_to_send_n,  // Port 1 clear-to-send, low active.
  input  wire logic        port1_set_ready_n,      // Port 1 set-ready, low active.
  input  wire logic        port1_carrier_detect_n, // Port 1 carrier detect, low active.
  input  wire logic        port1_ring_n,           // Port 1 ring, low active.
  input  wire logic        port2_clear_to_send_n,  // Port 2 clear-to-send, low active.
  input  wire logic        port2_set_ready_n,      // Port 2 set-ready, low active.
  input  wire logic        port2_carrier_detect_n, // Port 2 carrier detect, low active.
  input  wire logic        port2_ring_n,           // Port 2 ring, low active.
  input  wire logic        port2_strap_in,         // Level seen on port 2 send-request pin.
  output logic             port1_send_request_n,   // Port 1 send request, low active.
  output logic             port1_terminal_ready_n, // Port 1 terminal ready, low active.
  output logic             port2_send_request_n,   // Port 2 send request, low active.
  output logic             port2_terminal_ready_n, // Port 2 terminal ready, low active.
  output logic             config_base_strap,      // Strap level captured after reset.
  output logic      [11:0] config_index_base,      // Selected configuration index base.
  output logic             irq                     // Level interrupt, active high.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0]  p1_mcr_q;      // Port 1 modem control register.
  logic [7:0]  p2_mcr_q;      // Port 2 modem control register.
  logic [7:0]  p1_ier_q;      // Port 1 interrupt enable register.
  logic [7:0]  p2_ier_q;      // Port 2 interrupt enable register.
  logic [1:0]  int_stat_q;    // Sticky interrupt status, one bit per port.
  logic [1:0]  int_mask_q;    // Interrupt mask, one bit per port.
  logic [1:0]  int_stat_d;    // Next interrupt status.
  logic        strap_done_q;  // Strap has been captured since reset.
  logic        strap_q;       // Captured strap level.
  logic [31:0] prdata_q;      // Registered read data.
  logic        pready_q;      // Registered ready.
  logic        pslverr_q;     // Registered error.
  logic        irq_q;         // Registered interrupt level.
  logic        p1_rts_n_q;    // Port 1 send-request pin register.
  logic        p1_dtr_n_q;    // Port 1 terminal-ready pin register.
  logic        p2_rts_n_q;    // Port 2 send-request pin register.
  logic        p2_dtr_n_q;    // Port 2 terminal-ready pin register.

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port status trackers.
  logic [7:0]  p1_msr;        // Port 1 status image.
  logic [7:0]  p2_msr;        // Port 2 status image.
  logic        p1_change;     // Port 1 input change pulse.
  logic        p2_change;     // Port 2 input change pulse.
  logic [3:0]  p1_delta_clr;  // Port 1 change bits consumed by a read.
  logic [3:0]  p2_delta_clr;  // Port 2 change bits consumed by a read.

  // Port 1 status; clear-to-send only feeds this image and the change pulse, never a transmit gate.
  umh_port u_port1 (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .clear_to_send_n  (port1_clear_to_send_n),
    .set_ready_n      (port1_set_ready_n),
    .carrier_detect_n (port1_carrier_detect_n),
    .ring_n           (port1_ring_n),
    .delta_clr        (p1_delta_clr),
    .msr_q            (p1_msr),
    .change_q         (p1_change)
  );

  // Port 2 status, same structure as port 1.
  umh_port u_port2 (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .clear_to_send_n  (port2_clear_to_send_n),
    .set_ready_n      (port2_set_ready_n),
    .carrier_detect_n (port2_carrier_detect_n),
    .ring_n           (port2_ring_n),
    .delta_clr        (p2_delta_clr),
    .msr_q            (p2_msr),
    .change_q         (p2_change)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode.
  logic        setup_ph;      // Setup cycle of a transfer.
  logic        access_ph;     // Final access cycle of a transfer.
  logic        wr_acc;        // Write takes effect this edge.
  logic        rd_acc;        // Read completes this edge.
  logic        hit_p1_mcr;    // Address selects port 1 control.
  logic        hit_p1_msr;    // Address selects port 1 status.
  logic        hit_p1_ier;    // Address selects port 1 enable.
  logic        hit_p2_mcr;    // Address selects port 2 control.
  logic        hit_p2_msr;    // Address selects port 2 status.
  logic        hit_p2_ier;    // Address selects port 2 enable.
  logic        hit_stat;      // Address selects interrupt status.
  logic        hit_mask;      // Address selects interrupt mask.
  logic        hit_strap;     // Address selects strap register.
  logic        hit_any;       // Address is mapped.
  logic [31:0] rd_mux;        // Read data selected by address.
  logic [1:0]  stat_clr;      // Interrupt bits consumed by a read.
  logic [1:0]  int_set;       // Interrupt events this cycle.
  logic [7:0]  mcr_wdata;     // Write data limited to implemented control bits.
  logic [7:0]  ier_wdata;     // Write data limited to implemented enable bits.

  // Transfer phases; the slave always answers after one wait-free access cycle.
  assign setup_ph   = psel & ~penable;
  assign access_ph  = psel & penable & pready_q;
  assign wr_acc     = access_ph & pwrite & ~pslverr_q;
  assign rd_acc     = access_ph & ~pwrite & ~pslverr_q;

  // Address comparators.
  assign hit_p1_mcr = (paddr == UMH_OFF_P1_MCR);
  assign hit_p1_msr = (paddr == UMH_OFF_P1_MSR);
  assign hit_p1_ier = (paddr == UMH_OFF_P1_IER);
  assign hit_p2_mcr = (paddr == UMH_OFF_P2_MCR);
  assign hit_p2_msr = (paddr == UMH_OFF_P2_MSR);
  assign hit_p2_ier = (paddr == UMH_OFF_P2_IER);
  assign hit_stat   = (paddr == UMH_OFF_INT_STAT);
  assign hit_mask   = (paddr == UMH_OFF_INT_MASK);
  assign hit_strap  = (paddr == UMH_OFF_STRAP);
  assign hit_any    = hit_p1_mcr | hit_p1_msr | hit_p1_ier | hit_p2_mcr | hit_p2_msr |
                      hit_p2_ier | hit_stat | hit_mask | hit_strap;

  // Read multiplexer; unmapped addresses read as zero.
  assign rd_mux = hit_p1_mcr ? {24'h000000, p1_mcr_q} :
                  hit_p1_msr ? {24'h000000, p1_msr} :
                  hit_p1_ier ? {24'h000000, p1_ier_q} :
                  hit_p2_mcr ? {24'h000000, p2_mcr_q} :
                  hit_p2_msr ? {24'h000000, p2_msr} :
                  hit_p2_ier ? {24'h000000, p2_ier_q} :
                  hit_stat   ? {30'h00000000, int_stat_q} :
                  hit_mask   ? {30'h00000000, int_mask_q} :
                  hit_strap  ? {31'h00000000, strap_q} :
                               32'h00000000;

  // Only the bits captured in the read data are cleared, except the port interrupt bit that a modem
  // status read clears whole, so a change flag set between the setup and access edges stays pending for the next read.
  assign p1_delta_clr = (rd_acc & hit_p1_msr) ? prdata_q[3:0] : 4'h0;
  assign p2_delta_clr = (rd_acc & hit_p2_msr) ? prdata_q[3:0] : 4'h0;
  assign stat_clr     = {(rd_acc & hit_stat & prdata_q[UMH_INT_P2]) | (rd_acc & hit_p2_msr),
                         (rd_acc & hit_stat & prdata_q[UMH_INT_P1]) | (rd_acc & hit_p1_msr)};

  // Input changes raise an interrupt only while the port's enable bit is set.
  assign int_set    = {p2_change & p2_ier_q[UMH_IER_MODEM],
                       p1_change & p1_ier_q[UMH_IER_MODEM]};
  // A new event wins over a clear in the same cycle.
  assign int_stat_d = (int_stat_q & ~stat_clr) | int_set;

  // Implemented control bits: terminal ready, send request and loopback.
  assign mcr_wdata = pwdata[7:0] & ((8'h01 << UMH_MCR_TERM_READY) |
                                    (8'h01 << UMH_MCR_SEND_REQ) |
                                    (8'h01 << UMH_MCR_LOOPBACK));
  // Implemented enable bit: modem status interrupt.
  assign ier_wdata = pwdata[7:0] & (8'h01 << UMH_IER_MODEM);

  ////////////////////////////////////////////////////////////////////////////////
  // APB answer: data, ready and error are registered in the setup cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
      pready_q  <= 1'b1;
      pslverr_q <= ~hit_any;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers, written in the access cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p1_mcr_q <= UMH_MCR_RST;
      p2_mcr_q <= UMH_MCR_RST;
    end else if (wr_acc) begin
      if (hit_p1_mcr) begin
        p1_mcr_q <= mcr_wdata;
      end
      if (hit_p2_mcr) begin
        p2_mcr_q <= mcr_wdata;
      end
    end
  end

  // Interrupt enable registers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p1_ier_q <= UMH_IER_RST;
      p2_ier_q <= UMH_IER_RST;
    end else if (wr_acc) begin
      if (hit_p1_ier) begin
        p1_ier_q <= ier_wdata;
      end
      if (hit_p2_ier) begin
        p2_ier_q <= ier_wdata;
      end
    end
  end

  // Interrupt mask register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_mask_q <= UMH_INT_RST;
    end else if (wr_acc & hit_mask) begin
      int_mask_q <= pwdata[1:0];
    end
  end

  // Sticky interrupt status and the registered interrupt level.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_stat_q <= UMH_INT_RST;
      irq_q      <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      irq_q      <= |(int_stat_d & int_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Handshake outputs: low active, forced high in loopback and during reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p1_rts_n_q <= UMH_PIN_IDLE;
      p1_dtr_n_q <= UMH_PIN_IDLE;
      p2_rts_n_q <= UMH_PIN_IDLE;
      p2_dtr_n_q <= UMH_PIN_IDLE;
    end else begin
      p1_rts_n_q <= ~(p1_mcr_q[UMH_MCR_SEND_REQ] & ~p1_mcr_q[UMH_MCR_LOOPBACK]);
      p1_dtr_n_q <= ~(p1_mcr_q[UMH_MCR_TERM_READY] & ~p1_mcr_q[UMH_MCR_LOOPBACK]);
      p2_rts_n_q <= ~(p2_mcr_q[UMH_MCR_SEND_REQ] & ~p2_mcr_q[UMH_MCR_LOOPBACK]);
      p2_dtr_n_q <= ~(p2_mcr_q[UMH_MCR_TERM_READY] & ~p2_mcr_q[UMH_MCR_LOOPBACK]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture: the pin level is taken on the first edge after reset release,
  // since an asynchronous reset may only load constants.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_done_q <= 1'b0;
      strap_q      <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_q      <= port2_strap_in;
    end
  end

  // Registered strap outputs derived from the captured level.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_base_strap <= 1'b0;
      config_index_base <= UMH_BASE_STRAP0;
    end else begin
      config_base_strap <= strap_q;
      config_index_base <= strap_q ? UMH_BASE_STRAP1 : UMH_BASE_STRAP0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output assignments, all straight from flip-flops.
  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign irq                    = irq_q;
  assign port1_send_request_n   = p1_rts_n_q;
  assign port1_terminal_ready_n = p1_dtr_n_q;
  assign port2_send_request_n   = p2_rts_n_q;
  assign port2_terminal_ready_n = p2_dtr_n_q;

endmodule : umh_top

/* File: dv/umh_properties.sv */
// Port-level assertions for the modem handshake block.
module umh_properties
  import umh_pkg::*;
(
  input wire logic        clk,                    // Clock.
  input wire logic        sys_rst,                // Reset.
  input wire logic        psel,                   // Select.
  input wire logic        penable,                // Enable.
  input wire logic        pwrite,                 // Direction.
  input wire logic        pready,                 // Ready.
  input wire logic [7:0]  paddr,                  // Address.
  input wire logic [31:0] pwdata,                 // Write data.
  input wire logic [31:0] prdata,                 // Read data.
  input wire logic        port1_clear_to_send_n,  // Modem line.
  input wire logic        port2_strap_in,         // Strap level.
  input wire logic        port1_send_request_n,   // Handshake out.
  input wire logic        port1_terminal_ready_n, // Handshake out.
  input wire logic        port2_send_request_n,   // Handshake out.
  input wire logic        port2_terminal_ready_n, // Handshake out.
  input wire logic        config_base_strap,      // Captured strap.
  input wire logic [11:0] config_index_base       // Index base.
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Completed bus transfers, seen at their access edge.
  wire wr_done = psel && penable && pready && pwrite;   // Write taken.
  wire rd_done = psel && penable && pready && !pwrite;  // Read answered.
  a_send_req_p1 : assert property (wr_done && paddr == UMH_OFF_P1_MCR |-> ##2
    port1_send_request_n == !($past(pwdata[1], 2) && !$past(pwdata[4], 2)))
    else $error("port 1 send request wrong");
  a_term_ready_p1 : assert property (wr_done && paddr == UMH_OFF_P1_MCR |-> ##2
    port1_terminal_ready_n == !($past(pwdata[0], 2) && !$past(pwdata[4], 2)))
    else $error("port 1 terminal ready wrong");
  a_loopback_idle : assert property (wr_done && paddr == UMH_OFF_P2_MCR && pwdata[4]
    |-> ##2 port2_send_request_n && port2_terminal_ready_n) else $error("loopback not idle");
  a_reset_idle : assert property ($past(sys_rst) |-> port1_send_request_n &&
    port1_terminal_ready_n && port2_send_request_n && port2_terminal_ready_n)
    else $error("outputs active after reset");
  a_strap_capture : assert property ($past(sys_rst, 3) && !$past(sys_rst, 2) |->
    config_base_strap == $past(port2_strap_in, 2)) else $error("strap not captured");
  a_strap_base : assert property (config_index_base ==
    (config_base_strap ? UMH_BASE_STRAP1 : UMH_BASE_STRAP0)) else $error("index base wrong");
  a_cts_level : assert property (rd_done && paddr == UMH_OFF_P1_MSR |->
    prdata[4] == !$past(port1_clear_to_send_n, 2)) else $error("clear to send level wrong");
  a_read_clears : assert property (rd_done && paddr == UMH_OFF_P1_MSR ##3
    rd_done && paddr == UMH_OFF_P1_MSR |-> prdata[3:0] == 4'h0) else $error("flags kept");
endmodule : umh_properties

/* File: dv/umh_modem.sv */
// Modem model that drives the eight low-active handshake lines.
module umh_modem (
  input  wire logic       clk,     // Clock.
  input  wire logic       sys_rst, // Reset.
  input  wire logic [7:0] want_n,  // Levels asked for.
  output logic      [7:0] pins_n   // Lines to the block.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines move on the clock and rest inactive high after reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_n <= 8'hff;
    end else begin
      pins_n <= want_n;
    end
  end
endmodule : umh_modem

/* File: dv/test_uart_modem_handshake.sv */
// Self-checking bench for the modem handshake block.
module test_uart_modem_handshake import umh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, sys_rst = 1'b1, port2_strap_in = 1'b0; // Clock, reset, strap.
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;       // Bus controls.
  logic [7:0]  paddr = 8'h00, want_n = 8'hff, pins_n;            // Address and modem lines.
  logic [31:0] pwdata = 32'h0, seed = 32'h40, prdata;            // Data and xorshift state.
  logic        pready, pslverr, irq, config_base_strap;          // Status outputs.
  logic        port1_send_request_n, port1_terminal_ready_n;     // Port 1 outputs.
  logic        port2_send_request_n, port2_terminal_ready_n;     // Port 2 outputs.
  logic [11:0] config_index_base;                                // Index base.
  logic [32:0] exp_q[$], msk_q[$];                               // Noted results.
  int          miscompares = 0, n_compared = 0;                  // Counters.
  wire port1_clear_to_send_n = pins_n[0], port1_set_ready_n = pins_n[1];
  wire port1_ring_n = pins_n[2], port1_carrier_detect_n = pins_n[3];
  wire port2_clear_to_send_n = pins_n[4], port2_set_ready_n = pins_n[5];
  wire port2_ring_n = pins_n[6], port2_carrier_detect_n = pins_n[7];
  umh_top i_dut (.*);
  umh_modem i_modem (.clk(clk), .sys_rst(sys_rst), .want_n(want_n), .pins_n(pins_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock generator.
  initial begin
    forever #2 clk = ~clk;
  end
  // Xorshift source of stimulus.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Compares one result and counts it.
  task check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then stops.
  task summarize();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // One bus transfer; its expected answer is noted for the monitor.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
           input logic [32:0] m);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e}, '1);
  endtask : rd
  // Monitor takes the oldest note whenever an answer appears.
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [7:0] v, p, n;
    logic [1:0] c;
    int         i;
    v = rnd();
    port2_strap_in = v[0];
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    check({29'h0, port1_send_request_n, port1_terminal_ready_n, port2_send_request_n,
           port2_terminal_ready_n}, 33'hf);
    check({21'h0, config_index_base}, {21'h0, v[0] ? UMH_BASE_STRAP1 : UMH_BASE_STRAP0});
    rd(UMH_OFF_STRAP, {31'h0, v[0]});
    apb(1'b0, 8'h3c, 32'h0, {1'b1, 32'h0}, '1);
    // Random control words on both ports, loopback bit included.
    for (i = 0; i < 16; i++) begin
      v = rnd();
      wr(i[0] ? UMH_OFF_P2_MCR : UMH_OFF_P1_MCR, {24'h0, v});
      repeat (2) @(posedge clk);
      check({32'h0, i[0] ? port2_send_request_n : port1_send_request_n},
            {32'h0, !(v[1] && !v[4])});
      check({32'h0, i[0] ? port2_terminal_ready_n : port1_terminal_ready_n},
            {32'h0, !(v[0] && !v[4])});
      rd(i[0] ? UMH_OFF_P2_MCR : UMH_OFF_P1_MCR, {24'h0, v & 8'h13});
    end
    wr(UMH_OFF_P1_IER, 32'h8);
    wr(UMH_OFF_P2_IER, 32'h8);
    rd(UMH_OFF_P2_IER, 32'h8);
    p = 8'hff;
    // Random modem levels, random mask, then status and interrupt reads.
    for (i = 0; i < 12; i++) begin
      n = rnd();
      v = rnd();
      c = {|(n[7:4] ^ p[7:4]), |(n[3:0] ^ p[3:0])};
      wr(UMH_OFF_INT_MASK, {30'h0, v[1:0]});
      want_n <= n;
      repeat (5) @(posedge clk);
      check({32'h0, irq}, {32'h0, |(c & v[1:0])});
      rd(UMH_OFF_INT_STAT, {30'h0, c});
      rd(UMH_OFF_P1_MSR, {24'h0, ~n[3:0], n[3:0] & ~p[3:0]});
      rd(UMH_OFF_P1_MSR, {24'h0, ~n[3:0], 4'h0});
      rd(UMH_OFF_P2_MSR, {24'h0, ~n[7:4], n[7:4] & ~p[7:4]});
      check({32'h0, irq}, 33'h0);
      p = n;
    end
    summarize();
  end
endmodule : test_uart_modem_handshake
bind umh_top umh_properties i_props (.*);
